// file: verilog/irs_slave.sv
`timescale 1ns/1ns
`include "irs_map.svh"

// How it works
// - sda falling while scl high starts
// - sda rising while scl high stops
// - repeated start restarts the frame
// - sda changes only while scl low
// - eight bits msb first, then ack
// - ack is sda low in ninth slot
// - slave acks address, register, data bytes
// - write burst advances register pointer
// - read sends byte, pointer advances per acked byte
// - any byte count, stop ends it
// - answers 1011_0 plus two pin bits
// - aa written at 00 resets registers
// - test area stored, unmapped reads zero
// - id register fixed, writes ignored
// - bit0 software power-up, default off
// - bit2 amplifier enable, default on
// - bit1 pump enable, default on
module irs_slave #(
	parameter logic [7:0] CHIP_IDENTIFICATION = 8'h3c // arbitrary value
) (
	input  wire logic              i_mclk,        // system clock
	input  wire logic              i_reset,       // sync reset, high
	input  wire logic              i_scl,         // link clock from master
	input  wire logic              i_sda,         // sda wire level
	input  wire logic              i_addr_sel_lo, // addr_select_pin_low
	input  wire logic              i_addr_sel_hi, // addr_select_pin_high
	output logic                   o_sda_out,     // sda drive level
	output logic                   o_sda_oe,      // high pulls sda
	output irs_pkg::irs_ctrl_s     o_ctrl         // register fields
);

	////////////////////////////////////////////////////////////////////
	// link domain

	logic link_bit;

	// the only flop clocked by the master; everything else runs on the
	// system clock, so the data bit is held here through scl high and
	// only read back after it has crossed two more flops, long after it
	// settled, because scl must stay high for several system clocks
	// sda sampled on the master's rising edge
	always_ff @(posedge i_scl)
	begin
		link_bit <= i_sda;
	end

	////////////////////////////////////////////////////////////////////
	// synchronisers

	logic scl_m1;
	logic scl_m2;
	logic scl_m3;
	logic sda_m1;
	logic sda_m2;
	logic sda_m3;
	logic bit_m1;
	logic bit_m2;
	logic asel_lo_m1;
	logic asel_lo_m2;
	logic asel_hi_m1;
	logic asel_hi_m2;

	// two flops per foreign level, third stage for edge history
	// the third stage is only ever compared with the second, so no
	// logic reads a first-stage flop that may still be metastable
	always_ff @(posedge i_mclk)
	begin
		scl_m1     <= i_scl;
		scl_m2     <= scl_m1;
		scl_m3     <= scl_m2;
		sda_m1     <= i_sda;
		sda_m2     <= sda_m1;
		sda_m3     <= sda_m2;
		bit_m1     <= link_bit;
		bit_m2     <= bit_m1;
		asel_lo_m1 <= i_addr_sel_lo;
		asel_lo_m2 <= asel_lo_m1;
		asel_hi_m1 <= i_addr_sel_hi;
		asel_hi_m2 <= asel_hi_m1;
	end

	logic is_start;
	logic is_stop;
	logic is_fall;

	// conditions seen on the synchronised wires
	assign is_start = scl_m2 & scl_m3 & sda_m3 & ~sda_m2;
	assign is_stop  = scl_m2 & scl_m3 & ~sda_m3 & sda_m2;
	assign is_fall  = ~scl_m2 & scl_m3;

	////////////////////////////////////////////////////////////////////
	// register storage

	logic [7:0] regs [1:12];
	logic       wr_en;
	logic [3:0] wr_idx;
	logic [7:0] wr_data;
	logic       soft_rst;

	// storage index of a bus address
	function automatic logic [3:0] idx_of(input logic [7:0] a);
		logic [3:0] r;
		r = `IRS_IDX_NONE;
		if (a <= `IRS_OFS_LAST_LOW)
			r = a[3:0];
		else if (a == `IRS_OFS_ADP_THRESH)
			r = `IRS_IDX_ADP_THRESH;
		else if (a == `IRS_OFS_LIM1_MODE)
			r = `IRS_IDX_LIM1_MODE;
		return r;
	endfunction

	// default of each stored register
	function automatic logic [7:0] rst_of(input int i);
		logic [7:0] r;
		r = 8'h00;
		case (i)
			1:  r = `IRS_RST_SYSTEM_CONTROL;
			2:  r = `IRS_RST_MODE_CONTROL;
			3:  r = `IRS_RST_PUMP_OVERVOLTAGE_LIMIT;
			4:  r = `IRS_RST_CPP;
			5:  r = `IRS_RST_GAIN;
			6:  r = `IRS_RST_LIM3_OUT;
			7:  r = `IRS_RST_LIM3_TIME;
			8:  r = `IRS_RST_LIM2_OUT;
			9:  r = `IRS_RST_LIM2_TIME;
			10: r = `IRS_RST_LIM1_CTRL;
			11: r = `IRS_RST_ADP_THRESH;
			12: r = `IRS_RST_LIM1_MODE;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// magic value at the id address wipes the map
	assign soft_rst = wr_en && (wr_idx == 4'h0)
		&& (wr_data == `IRS_SOFT_RESET_VAL);

	// one flop bank per register; id address has no storage
	genvar g;
	generate
		for (g = 1; g <= 12; g++)
		begin : g_reg
			always_ff @(posedge i_mclk)
			begin
				if (i_reset || soft_rst)
					regs[g] <= rst_of(g);
				else if (wr_en && (wr_idx == 4'(g)))
				begin
					// illegal limit codes fall back to default
					if ((g == 3) && (wr_data[3:0] > `IRS_PUMP_OVERVOLTAGE_LIMIT_MAX))
						regs[g] <= `IRS_RST_PUMP_OVERVOLTAGE_LIMIT;
					else
						regs[g] <= wr_data;
				end
			end
		end
	endgenerate

	// read mux: id constant, stored bytes, zero elsewhere
	function automatic logic [7:0] rd_of(input logic [7:0] a);
		logic [3:0] i;
		logic [7:0] r;
		i = idx_of(a);
		r = 8'h00;
		if (i == 4'h0)
			r = CHIP_IDENTIFICATION;
		else if (i <= `IRS_IDX_LIM1_MODE)
			r = regs[i];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// protocol engine

	irs_pkg::irs_state_e state;
	logic [3:0]          cnt;
	logic                got;
	logic [7:0]          shreg;
	logic [7:0]          ptr;
	logic [7:0]          tx;
	logic                rw;
	logic [7:0]          nb;
	logic [6:0]          my_addr;
	logic [7:0]          rd_cur;
	logic [7:0]          rd_nxt;

	// byte completed by the bit on this falling edge
	assign nb      = {shreg[6:0], bit_m2};
	assign my_addr = {`IRS_DEV_ADDR_HI, asel_hi_m2, asel_lo_m2};

	// bytes at and just after the pointer, named so that their top bit
	// can be picked; the next byte is ready before the master acks
	assign rd_cur = rd_of(ptr);
	assign rd_nxt = rd_of(ptr + 8'h01);

	// the engine acts only on synchronised scl falls, so every change
	// of the sda enable lands a few system clocks into scl low; this
	// trades a little hold margin for one clock domain in the logic
	// limitation: scl low and high must each last several system clocks

	// every sda change is made just after scl is seen low
	always_ff @(posedge i_mclk)
	begin
		wr_en <= 1'b0;
		if (i_reset)
		begin
			state    <= irs_pkg::ST_IDLE;
			cnt      <= 4'h0;
			got      <= 1'b0;
			shreg    <= 8'h00;
			ptr      <= 8'h00;
			tx       <= 8'h00;
			rw       <= 1'b0;
			wr_idx   <= 4'h0;
			wr_data  <= 8'h00;
			o_sda_oe <= 1'b0;
		end
		else if (is_start)
		begin
			// a repeated start is treated like any start
			state    <= irs_pkg::ST_DEV;
			cnt      <= 4'h0;
			got      <= 1'b0;
			o_sda_oe <= 1'b0;
		end
		else if (is_stop)
		begin
			state    <= irs_pkg::ST_IDLE;
			o_sda_oe <= 1'b0;
		end
		else if (is_fall && (state != irs_pkg::ST_IDLE))
		begin
			if (!got)
				got <= 1'b0 | 1'b1; // first fall ends the start
			else if (cnt < 4'h8)
			begin
				// collect bit msb first
				shreg <= nb;
				cnt   <= cnt + 4'h1;
				if (cnt == 4'h7)
				begin
					// decide what goes on the wire in the ack slot
					unique case (state)
						irs_pkg::ST_DEV:
						begin
							if (nb[7:1] == my_addr)
							begin
								o_sda_oe <= 1'b1;
								rw       <= nb[0];
							end
							else
							begin
								state    <= irs_pkg::ST_IDLE;
								o_sda_oe <= 1'b0;
							end
						end
						irs_pkg::ST_REG:
						begin
							ptr      <= nb;
							o_sda_oe <= 1'b1;
						end
						irs_pkg::ST_WDATA:
						begin
							wr_data  <= nb;
							o_sda_oe <= 1'b1;
						end
						irs_pkg::ST_RDATA:
							o_sda_oe <= 1'b0; // master owns ack
						irs_pkg::ST_IDLE:
							o_sda_oe <= 1'b0;
					endcase
				end
				else if (state == irs_pkg::ST_RDATA)
					o_sda_oe <= ~tx[3'(6 - cnt)];
			end
			else
			begin
				// ack slot just ended
				cnt <= 4'h0;
				unique case (state)
					irs_pkg::ST_DEV:
					begin
						if (rw)
						begin
							// send the addressed byte first
							state    <= irs_pkg::ST_RDATA;
							tx       <= rd_cur;
							o_sda_oe <= ~rd_cur[7];
						end
						else
						begin
							state    <= irs_pkg::ST_REG;
							o_sda_oe <= 1'b0;
						end
					end
					irs_pkg::ST_REG:
					begin
						state    <= irs_pkg::ST_WDATA;
						o_sda_oe <= 1'b0;
					end
					irs_pkg::ST_WDATA:
					begin
						// commit, then advance the pointer
						wr_en    <= 1'b1;
						wr_idx   <= idx_of(ptr);
						ptr      <= ptr + 8'h01;
						o_sda_oe <= 1'b0;
					end
					irs_pkg::ST_RDATA:
					begin
						if (bit_m2)
						begin
							// master declined: leave the bus alone
							state    <= irs_pkg::ST_IDLE;
							o_sda_oe <= 1'b0;
						end
						else
						begin
							ptr      <= ptr + 8'h01;
							tx       <= rd_nxt;
							o_sda_oe <= ~rd_nxt[7];
						end
					end
					irs_pkg::ST_IDLE:
						o_sda_oe <= 1'b0;
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge i_mclk)
	begin
		o_sda_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// control fields

	// decoded straight from the register flops
	// no decode gates sit between flop and port, so the analog side
	// never sees a glitch while a byte is committed
	assign o_ctrl.pump_amp_powerup       = regs[1][`IRS_BIT_PUMP_AMP_PU];
	assign o_ctrl.pump_enable            = regs[1][`IRS_BIT_PUMP_EN];
	assign o_ctrl.amp_enable             = regs[1][`IRS_BIT_AMP_EN];
	assign o_ctrl.linear_class_select    = regs[2][`IRS_BIT_LIN_CLASS];
	assign o_ctrl.loudspeaker_select     = regs[2][`IRS_BIT_SPK_SEL];
	assign o_ctrl.doubler_select         = regs[2][`IRS_BIT_DOUBLER];
	assign o_ctrl.adaptive_supply_enable = regs[2][`IRS_BIT_ADP_EN];
	assign o_ctrl.pump_voltage_limit     = regs[3][3:0];
	assign o_ctrl.pump_parameter         = regs[4];
	assign o_ctrl.amp_gain               = regs[5];
	assign o_ctrl.lim3_output            = regs[6];
	assign o_ctrl.lim3_timing            = regs[7];
	assign o_ctrl.lim2_output            = regs[8];
	assign o_ctrl.lim2_timing            = regs[9];
	assign o_ctrl.lim1_control           = regs[10];
	assign o_ctrl.adp_threshold          = regs[11];
	assign o_ctrl.lim1_mode              = regs[12];

endmodule

// file: inc/irs_map.svh
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH

// register offsets
`define IRS_OFS_CHIP_IDENTIFICATION     8'h00
`define IRS_OFS_SYSTEM_CONTROL     8'h01
`define IRS_OFS_MODE_CONTROL    8'h02
`define IRS_OFS_PUMP_OVERVOLTAGE_LIMIT       8'h03
`define IRS_OFS_LAST_LOW    8'h0a
`define IRS_OFS_ADP_THRESH  8'h63
`define IRS_OFS_LIM1_MODE   8'h64

// storage indices for the two high test-area registers
`define IRS_IDX_ADP_THRESH  4'hb
`define IRS_IDX_LIM1_MODE   4'hc
`define IRS_IDX_NONE        4'hf

// reset values
`define IRS_RST_SYSTEM_CONTROL     8'h06
`define IRS_RST_MODE_CONTROL    8'h0c
`define IRS_RST_PUMP_OVERVOLTAGE_LIMIT       8'h08
`define IRS_RST_CPP         8'h05
`define IRS_RST_GAIN        8'h0c
`define IRS_RST_LIM3_OUT    8'h07
`define IRS_RST_LIM3_TIME   8'h4e
`define IRS_RST_LIM2_OUT    8'h06
`define IRS_RST_LIM2_TIME   8'h08
`define IRS_RST_LIM1_CTRL   8'h4a
`define IRS_RST_ADP_THRESH  8'h05
`define IRS_RST_LIM1_MODE   8'h28

// field positions
`define IRS_BIT_PUMP_AMP_PU 0
`define IRS_BIT_PUMP_EN     1
`define IRS_BIT_AMP_EN      2
`define IRS_BIT_LIN_CLASS   0
`define IRS_BIT_SPK_SEL     2
`define IRS_BIT_DOUBLER     3
`define IRS_BIT_ADP_EN      4

// largest legal pump voltage limit code
`define IRS_PUMP_OVERVOLTAGE_LIMIT_MAX       4'ha

// slave address and soft reset
`define IRS_DEV_ADDR_HI     5'b10110
`define IRS_SOFT_RESET_VAL  8'haa

`endif

// file: inc/irs_pkg.sv
package irs_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_DEV   = 3'b001,
		ST_REG   = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100
	} irs_state_e;

	typedef struct packed {
		logic       amp_enable;
		logic       pump_enable;
		logic       pump_amp_powerup;
		logic       adaptive_supply_enable;
		logic       doubler_select;
		logic       loudspeaker_select;
		logic       linear_class_select;
		logic [3:0] pump_voltage_limit;
		logic [7:0] pump_parameter;
		logic [7:0] amp_gain;
		logic [7:0] lim3_output;
		logic [7:0] lim3_timing;
		logic [7:0] lim2_output;
		logic [7:0] lim2_timing;
		logic [7:0] lim1_control;
		logic [7:0] adp_threshold;
		logic [7:0] lim1_mode;
	} irs_ctrl_s;

endpackage

// file: tb/irs_slave_monitor.sv
`timescale 1ns/1ns
// watches the slave pins; all checks on the system clock
module irs_slave_monitor (
	input wire logic               i_mclk,        // system clock
	input wire logic               i_reset,       // sync reset
	input wire logic               i_scl,         // bus clock
	input wire logic               i_sda,         // sda level
	input wire logic               i_addr_sel_lo, // pin bit
	input wire logic               i_addr_sel_hi, // pin bit
	input wire logic               o_sda_out,     // drive level
	input wire logic               o_sda_oe,      // drive enable
	input wire irs_pkg::irs_ctrl_s o_ctrl         // fields
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	chk_drive_low: assert property (o_sda_out == 1'b0)
		else $error("sda drive level not low");
	chk_oe_hold: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
		else $error("sda enable moved in scl high");
	chk_oe_lag: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
		else $error("sda enable moved too near scl fall");
	chk_oe_span: assert property ($rose(o_sda_oe) |-> ##[1:500] !o_sda_oe)
		else $error("sda held low too long");
	chk_start_rx: assert property (i_scl && $fell(i_sda) |-> !o_sda_oe [*8])
		else $error("sda driven after start");
	chk_stop_idle: assert property (i_scl && $rose(i_sda) |-> !o_sda_oe [*8])
		else $error("sda driven after stop");
	chk_reset_fields: assert property ($past(i_reset) |-> o_ctrl.amp_enable
		&& o_ctrl.pump_enable && !o_ctrl.pump_amp_powerup)
		else $error("control defaults wrong");
	chk_ctrl_in_low: assert property ($changed(o_ctrl) |-> !i_scl && !$past(i_scl, 2))
		else $error("register changed outside scl low");
endmodule

// file: tb/irs_host.sv
`timescale 1ns/1ns
// behavioural bus controller; scl stands high between frames
module irs_host #(
	parameter int Q = 60 // quarter bit in ns
) (
	input  wire logic i_sda, // resolved sda
	output logic      o_scl, // bus clock
	output logic      o_sda  // 0 pulls, 1 releases
);
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// data set mid-low, sampled mid-high
	task automatic clk(input logic b, output logic r);
		#Q o_sda = b;
		#Q o_scl = 1'b1;
		#Q r = i_sda;
		#Q o_scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic k, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--)
			clk(d[i], q[i]);
		clk(k, a);
	endtask
	task automatic start();
		#Q o_sda = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda = 1'b0;
		#Q o_scl = 1'b0;
	endtask
	task automatic stop();
		#Q o_sda = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda = 1'b1;
	endtask
endmodule

// file: tb/irs_slave_tb.sv
`timescale 1ns/1ns
module irs_slave_tb;
	logic               mclk;
	logic               rst;
	logic               scl;
	logic               sda_m;
	logic               hi;
	logic               lo;
	logic               sda_out;
	logic               sda_oe;
	irs_pkg::irs_ctrl_s ctrl;
	wire logic          sda;
	logic [6:0]         da;
	logic [7:0]         rb [16];
	int                 err_count;
	int                 cmp_count;
	logic [7:0]         dflt [11] = '{8'h5e, 8'h06, 8'h0c, 8'h08, 8'h05, 8'h0c,
		8'h07, 8'h4e, 8'h06, 8'h08, 8'h4a};

	// pull-up wire: low if either side pulls
	assign sda = sda_m & ~sda_oe;

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	irs_host h (.i_sda(sda), .o_scl(scl), .o_sda(sda_m));
	irs_slave #(.CHIP_IDENTIFICATION(8'h5e)) DUT (.i_mclk(mclk), .i_reset(rst), .i_scl(scl),
		.i_sda(sda), .i_addr_sel_lo(lo), .i_addr_sel_hi(hi), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .o_ctrl(ctrl));

	task automatic end_sim();
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// write n bytes d, d+1.. from register ra; acks must equal nak
	task automatic wr(input logic [7:0] ra, input logic [7:0] d, input int n,
		input logic nak);
		logic [7:0] q;
		logic       a;
		h.start();
		h.xfer({da, 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, {7'h0, nak});
		h.xfer(ra, 1'b1, q, a);
		chk({7'h0, a}, {7'h0, nak});
		for (int i = 0; i < n; i++)
		begin
			h.xfer(d + 8'(i), 1'b1, q, a);
			chk({7'h0, a}, {7'h0, nak});
		end
		h.stop();
	endtask

	// pointer write, then restart (sr) or stop-start, n bytes, last nacked
	task automatic rd(input logic [7:0] ra, input int n, input logic sr);
		logic [7:0] q;
		logic       a;
		h.start();
		h.xfer({da, 1'b0}, 1'b1, q, a);
		h.xfer(ra, 1'b1, q, a);
		if (!sr)
			h.stop();
		h.start();
		h.xfer({da, 1'b1}, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		for (int i = 0; i < n; i++)
			h.xfer(8'hff, i == n - 1, rb[i], a);
		h.stop();
	endtask

	initial
	begin
		#700000;
		err_count++;
		end_sim();
	end

	initial
	begin
		rst = 1'b1;
		hi = 1'b0;
		lo = 1'b0;
		da = 7'h58;
		err_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		// id and defaults by one burst
		rd(8'h00, 11, 1'b1);
		for (int i = 0; i < 11; i++)
			chk(rb[i], dflt[i]);
		rd(8'h63, 2, 1'b0);
		chk(rb[0], 8'h05);
		chk(rb[1], 8'h28);
		// write burst lands in consecutive registers
		wr(8'h05, 8'h11, 3, 1'b0);
		chk(ctrl.amp_gain, 8'h11);
		chk(ctrl.lim3_output, 8'h12);
		chk(ctrl.lim3_timing, 8'h13);
		rd(8'h05, 3, 1'b0);
		for (int i = 0; i < 3; i++)
			chk(rb[i], 8'h11 + 8'(i));
		wr(8'h01, 8'h01, 1, 1'b0);
		chk({5'h0, ctrl.amp_enable, ctrl.pump_enable, ctrl.pump_amp_powerup}, 8'h01);
		// id ignores writes, aa resets all
		wr(8'h00, 8'h12, 1, 1'b0);
		rd(8'h00, 1, 1'b1);
		chk(rb[0], 8'h5e);
		wr(8'h00, 8'haa, 1, 1'b0);
		chk(ctrl.amp_gain, 8'h0c);
		chk({5'h0, ctrl.amp_enable, ctrl.pump_enable, ctrl.pump_amp_powerup}, 8'h06);
		// reserved limit code falls back, unmapped address reads zero
		wr(8'h03, 8'h0f, 1, 1'b0);
		chk({4'h0, ctrl.pump_voltage_limit}, 8'h08);
		rd(8'h0b, 1, 1'b1);
		chk(rb[0], 8'h00);
		// foreign address ignored
		da = 7'h59;
		wr(8'h05, 8'h33, 1, 1'b1);
		chk(ctrl.amp_gain, 8'h0c);
		// every pin setting
		for (int p = 0; p < 4; p++)
		begin
			@(posedge mclk);
			{hi, lo} <= 2'(p);
			repeat (4) @(posedge mclk);
			da = 7'h58 + 7'(p);
			wr(8'h05, 8'(p), 1, 1'b0);
			chk(ctrl.amp_gain, 8'(p));
		end
		end_sim();
	end
endmodule

bind irs_slave irs_slave_monitor u_mon (.i_mclk(i_mclk), .i_reset(i_reset),
	.i_scl(i_scl), .i_sda(i_sda), .i_addr_sel_lo(i_addr_sel_lo),
	.i_addr_sel_hi(i_addr_sel_hi), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_ctrl(o_ctrl));
